// ### design/rdac_ctrl.sv
// Purpose: register file and switch control of an 8-bit reference converter
// Assumes: one clock I_MCLK at 50 MHz, synchronous active-high reset I_SRST
// Notes: the analog ladder sits outside; this block drives its tap and switches
//
// Function
// - converter runs only while enable bit set
// - 8-bit level code selects one of 256
// - level also offered to comparator and ADC
// - pin enable bits route level to pins
// - routed pin loses digital driver and input
// - digital read of routed pin returns zero
// - keeps running in sleep, wake preserves control
// - reset disables, disconnects, clears level code
// - bits 6 and 1 read zero
// - implemented bits read/write, reset zero
`timescale 1ns/1ps
module rdac_ctrl
(
    input wire logic I_MCLK,
    input wire logic I_SRST,
    input wire logic I_CLK_EN,
    input wire logic I_SLEEP,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [1:0] I_DIG_OUT,
    input wire logic [1:0] I_DIG_OE_N,
    input wire logic [1:0] I_PAD_IN,
    output logic [1:0] O_PAD_OUT,
    output logic [1:0] O_PAD_OE_N,
    output logic [1:0] O_PIN_READ,
    output logic [1:0] O_ANA_PIN_SW,
    output logic O_LADDER_ON,
    output logic [7:0] O_LADDER_TAP,
    output logic O_REF_TO_CMP,
    output logic O_REF_TO_ADC,
    output rdac_pkg::rdac_switch_t O_SRC_SW
);
    rdac_pkg::rdac_ctrl_t ctrl_ff;
    logic [7:0] level_ff;
    logic [1:0] pad_meta_ff;
    logic [1:0] pad_sync_ff;
    logic [1:0] pin_sel;
    logic [1:0] pad_out_c;
    logic [1:0] pad_oe_n_c;
    logic [1:0] ana_sw_c;
    logic [1:0] read_c;
    logic wr_en;
    logic rd_en;
    logic hit_ctrl;
    logic hit_level;
    logic [7:0] nxt_ctrl_byte;

    function automatic logic [7:0] ctrl_to_byte(input rdac_pkg::rdac_ctrl_t c);
        logic [7:0] b;
        b = 8'h00;
        b[rdac_pkg::BIT_ENABLE] = c.converter_enable;
        b[rdac_pkg::BIT_OUT_PIN1] = c.out_pin1_enable;
        b[rdac_pkg::BIT_OUT_PIN2] = c.out_pin2_enable;
        b[rdac_pkg::BIT_PSS_HI:rdac_pkg::BIT_PSS_LO] = c.positive_source_select;
        b[rdac_pkg::BIT_NSS] = c.negative_source_select;
        return b;
    endfunction : ctrl_to_byte

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : addr_is

    // one decode of a control byte, shared by reset and write
    function automatic rdac_pkg::rdac_ctrl_t byte_to_ctrl(input logic [7:0] b);
        rdac_pkg::rdac_ctrl_t c;
        c.converter_enable = b[rdac_pkg::BIT_ENABLE];
        c.out_pin1_enable = b[rdac_pkg::BIT_OUT_PIN1];
        c.out_pin2_enable = b[rdac_pkg::BIT_OUT_PIN2];
        c.positive_source_select = rdac_pkg::rdac_pss_t'(
            b[rdac_pkg::BIT_PSS_HI:rdac_pkg::BIT_PSS_LO]);
        c.negative_source_select = b[rdac_pkg::BIT_NSS];
        return c;
    endfunction : byte_to_ctrl

    assign hit_ctrl = addr_is(I_PADDR, rdac_pkg::OFF_CONTROL_0);
    assign hit_level = addr_is(I_PADDR, rdac_pkg::OFF_LEVEL_CODE);
    // write in apb access phase, read taken in setup phase; the slave answers in the cycle after setup
    assign wr_en = I_CLK_EN && I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
    assign rd_en = I_CLK_EN && I_PSEL && !I_PENABLE && !I_PWRITE;
    // unimplemented bits dropped on write
    assign nxt_ctrl_byte = I_PWDATA[7:0] & rdac_pkg::CONTROL_0_IMPL_MASK;

    // control register 0; sleep does not touch it
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            ctrl_ff <= byte_to_ctrl(rdac_pkg::CONTROL_0_RESET);
        end
        else if (wr_en && hit_ctrl && I_PSTRB[0])
        begin
            ctrl_ff <= byte_to_ctrl(nxt_ctrl_byte);
        end
    end

    // level code register
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            level_ff <= rdac_pkg::LEVEL_CODE_RESET;
        end
        else if (wr_en && hit_level && I_PSTRB[0])
        begin
            level_ff <= I_PWDATA[7:0];
        end
    end

    // apb answer: ready one cycle after setup, error on unmapped address
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
        end
        else if (I_CLK_EN)
        begin
            O_PREADY <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= I_PSEL && !I_PENABLE && !(hit_ctrl || hit_level);
            if (rd_en && hit_ctrl)
            begin
                O_PRDATA <= {24'h00_0000, ctrl_to_byte(ctrl_ff)};
            end
            else if (rd_en && hit_level)
            begin
                O_PRDATA <= {24'h00_0000, level_ff};
            end
            else if (rd_en)
            begin
                O_PRDATA <= 32'h0000_0000;
            end
        end
    end

    // two-flop synchroniser of the pads
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            pad_meta_ff <= 2'b00;
            pad_sync_ff <= 2'b00;
        end
        else if (I_CLK_EN)
        begin
            pad_meta_ff <= I_PAD_IN;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    assign pin_sel = {ctrl_ff.out_pin2_enable, ctrl_ff.out_pin1_enable};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            rdac_pin_ovr u_pin
            (
                .i_analog_sel(pin_sel[g]),
                .i_dig_out(I_DIG_OUT[g]),
                .i_dig_oe_n(I_DIG_OE_N[g]),
                .i_pad_sync(pad_sync_ff[g]),
                .o_pad_out(pad_out_c[g]),
                .o_pad_oe_n(pad_oe_n_c[g]),
                .o_ana_sw(ana_sw_c[g]),
                .o_read_val(read_c[g])
            );
        end
    endgenerate

    // pad and analog outputs registered; sleep input deliberately unused for gating
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            O_PAD_OUT <= 2'b00;
            O_PAD_OE_N <= 2'b11;
            O_PIN_READ <= 2'b00;
            O_ANA_PIN_SW <= 2'b00;
        end
        else if (I_CLK_EN)
        begin
            O_PAD_OUT <= pad_out_c;
            O_PAD_OE_N <= pad_oe_n_c;
            O_PIN_READ <= read_c;
            O_ANA_PIN_SW <= ana_sw_c;
        end
    end

    // ladder and reference switches follow registers one edge later, sleep or not
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            O_LADDER_ON <= 1'b0;
            O_LADDER_TAP <= rdac_pkg::LEVEL_CODE_RESET;
            O_REF_TO_CMP <= 1'b0;
            O_REF_TO_ADC <= 1'b0;
            O_SRC_SW <= rdac_pkg::rdac_switch_t'(5'h00);
        end
        else if (I_CLK_EN)
        begin
            O_LADDER_ON <= ctrl_ff.converter_enable;
            O_LADDER_TAP <= level_ff;
            O_REF_TO_CMP <= ctrl_ff.converter_enable;
            O_REF_TO_ADC <= ctrl_ff.converter_enable;
            O_SRC_SW.pos_supply <=
                ctrl_ff.positive_source_select == rdac_pkg::PSS_SUPPLY;
            O_SRC_SW.pos_ext_pin <=
                ctrl_ff.positive_source_select == rdac_pkg::PSS_EXT_PIN;
            O_SRC_SW.pos_fixed_reference <=
                ctrl_ff.positive_source_select == rdac_pkg::PSS_FIXED_REF;
            O_SRC_SW.neg_ext_pin <= ctrl_ff.negative_source_select;
            O_SRC_SW.neg_ground <= !ctrl_ff.negative_source_select;
        end
    end
endmodule : rdac_ctrl

// ### design/rdac_pkg.sv
// Purpose: shared constants and carriers for the reference converter control block
// Assumes: APB slave with 32-bit data, byte addresses below
// Notes: offsets are the block's own register map
package rdac_pkg;
    localparam logic [11:0] OFF_CONTROL_0 = 12'h000;
    localparam logic [11:0] OFF_LEVEL_CODE = 12'h004;
    localparam logic [7:0] CONTROL_0_RESET = 8'h00;
    localparam logic [7:0] LEVEL_CODE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_0_IMPL_MASK = 8'hbd;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_OUT_PIN1 = 5;
    localparam int BIT_OUT_PIN2 = 4;
    localparam int BIT_PSS_HI = 3;
    localparam int BIT_PSS_LO = 2;
    localparam int BIT_NSS = 0;
    localparam int LEVEL_COUNT = 256;

    typedef enum logic [1:0]
    {
        PSS_SUPPLY = 2'b00,
        PSS_EXT_PIN = 2'b01,
        PSS_FIXED_REF = 2'b10,
        PSS_RESERVED = 2'b11
    } rdac_pss_t;

    typedef struct packed
    {
        logic converter_enable;
        logic out_pin1_enable;
        logic out_pin2_enable;
        rdac_pss_t positive_source_select;
        logic negative_source_select;
    } rdac_ctrl_t;

    typedef struct packed
    {
        logic pos_supply;
        logic pos_ext_pin;
        logic pos_fixed_reference;
        logic neg_ext_pin;
        logic neg_ground;
    } rdac_switch_t;
endpackage : rdac_pkg

// ### design/rdac_pin_ovr.sv
// Purpose: digital override of one pin that may carry the converter level
// Assumes: pad input already synchronised by the caller
// Notes: one instance per output pin
`timescale 1ns/1ps
module rdac_pin_ovr
(
    input wire logic i_analog_sel,
    input wire logic i_dig_out,
    input wire logic i_dig_oe_n,
    input wire logic i_pad_sync,
    output logic o_pad_out,
    output logic o_pad_oe_n,
    output logic o_ana_sw,
    output logic o_read_val
);
    always_comb
    begin
        // analog routing kills the digital driver and the input detector
        o_ana_sw = i_analog_sel;
        o_pad_out = i_analog_sel ? 1'b0 : i_dig_out;
        o_pad_oe_n = i_analog_sel ? 1'b1 : i_dig_oe_n;
        o_read_val = i_analog_sel ? 1'b0 : i_pad_sync;
    end
endmodule : rdac_pin_ovr

// ### tb/rdac_ctrl_sva.sv
// Purpose: port assertions for the reference converter control block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to rdac_ctrl below
`timescale 1ns/1ps
module rdac_ctrl_sva
(
    input wire logic I_MCLK,
    input wire logic I_SRST,
    input wire logic I_CLK_EN,
    input wire logic I_SLEEP,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [1:0] O_PAD_OE_N,
    input wire logic [1:0] O_PIN_READ,
    input wire logic [1:0] O_ANA_PIN_SW,
    input wire logic O_LADDER_ON,
    input wire logic [7:0] O_LADDER_TAP,
    input wire logic O_REF_TO_CMP,
    input wire logic O_REF_TO_ADC
);
    logic [7:0] wd_ff;
    logic wr_ok;
    assign wr_ok = O_PREADY && I_PWRITE && I_PSTRB[0];
    always_ff @(posedge I_MCLK)
    begin
        if (wr_ok)
            wd_ff <= I_PWDATA[7:0];
    end
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SRST);
    a_ready_after_setup:
        assert property (I_PSEL && !I_PENABLE && I_CLK_EN |=> O_PREADY) else $error("no ready");
    a_ready_one_cycle:
        assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
    a_err_unmapped:
        assert property (O_PREADY |-> O_PSLVERR == !(I_PADDR == 12'h000 || I_PADDR == 12'h004))
        else $error("slave error wrong");
    a_tap_update:
        assert property (wr_ok && I_PADDR == 12'h004 |-> ##[1:2] O_LADDER_TAP == wd_ff)
        else $error("tap not updated");
    a_enable_apply:
        assert property (wr_ok && I_PADDR == 12'h000 |-> ##[1:2] O_LADDER_ON == wd_ff[7])
        else $error("enable not applied");
    a_cmp_adc_ref:
        assert property (O_REF_TO_CMP == O_LADDER_ON && O_REF_TO_ADC == O_LADDER_ON)
        else $error("reference taps wrong");
    a_pin_released:
        assert property ((O_ANA_PIN_SW & ~O_PAD_OE_N) == 2'b00) else $error("pin still driven");
    a_read_zero:
        assert property ((O_ANA_PIN_SW & O_PIN_READ) == 2'b00) else $error("routed pin read");
    a_sleep_hold:
        assert property ((I_SLEEP && !I_PSEL) [*3] |-> $stable(O_LADDER_ON) && $stable(O_ANA_PIN_SW))
        else $error("state moved in sleep");
    a_reset_clear:
        assert property (disable iff (1'b0) I_SRST |=> !O_LADDER_ON && O_ANA_PIN_SW == 2'b00
            && O_LADDER_TAP == 8'h00) else $error("reset did not clear");
endmodule : rdac_ctrl_sva
bind rdac_ctrl rdac_ctrl_sva u_sva
(
    .I_MCLK(I_MCLK),
    .I_SRST(I_SRST),
    .I_CLK_EN(I_CLK_EN),
    .I_SLEEP(I_SLEEP),
    .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA),
    .I_PSTRB(I_PSTRB),
    .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR),
    .O_PAD_OE_N(O_PAD_OE_N),
    .O_PIN_READ(O_PIN_READ),
    .O_ANA_PIN_SW(O_ANA_PIN_SW),
    .O_LADDER_ON(O_LADDER_ON),
    .O_LADDER_TAP(O_LADDER_TAP),
    .O_REF_TO_CMP(O_REF_TO_CMP),
    .O_REF_TO_ADC(O_REF_TO_ADC)
);

// ### tb/testbench.sv
// Purpose: register-level bench for the reference converter control block
// Assumes: APB master in this bench, 50 MHz clock
// Notes: pads and digital port driven directly
`timescale 1ns/1ps
module testbench;
    logic clk, srst, ce, slp, psel, pen, pwr;
    logic [11:0] pa;
    logic [31:0] pwd, prd, rdata;
    logic [3:0] stb;
    logic prdy, perr, rerr, on, cmp, adc;
    logic [1:0] dout, doen, pin, pout, poen, pread, asw;
    logic [7:0] tap;
    rdac_pkg::rdac_switch_t ssw;
    int failures = 0;
    int total_checks = 0;
    logic [7:0] lv [5] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h5a};
    rdac_ctrl dut (.I_MCLK(clk), .I_SRST(srst), .I_CLK_EN(ce), .I_SLEEP(slp), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .I_PSTRB(stb),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .I_DIG_OUT(dout), .I_DIG_OE_N(doen),
        .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE_N(poen), .O_PIN_READ(pread),
        .O_ANA_PIN_SW(asw), .O_LADDER_ON(on), .O_LADDER_TAP(tap), .O_REF_TO_CMP(cmp),
        .O_REF_TO_ADC(adc), .O_SRC_SW(ssw));
    task wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1 && ++n < 50);
        if (n >= 50)
            failures++;
        rdata = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end
    initial
    begin
        {srst, ce, slp, psel, pen, pwr, pa, pwd} = {3'h6, 47'h0};
        {stb, dout, doen, pin} = {4'hf, 2'h3, 2'h0, 2'h3};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 32'h0);
        // pins not routed after reset, so the digital enable owns the pads
        chk(32'({asw, poen}), 32'h0);
        apb(1'b1, 12'h000, 32'hfb);
        settle();
        chk(32'(on), 32'h1);
        chk(32'(cmp & adc), 32'h1);
        chk(32'(asw), 32'h3);
        chk(32'(poen), 32'h3);
        chk(32'(pread), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'hb9);
        slp <= 1'b1;
        settle();
        chk(32'(on), 32'h1);
        slp <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'hb9);
        // software clears the enable before sleeping
        apb(1'b1, 12'h000, 32'h39);
        settle();
        slp <= 1'b1;
        settle();
        chk(32'({on, cmp, adc}), 32'h0);
        slp <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h39);
        $display("test done: enable and pins");
        {dout, doen, pin} <= 6'h26;
        apb(1'b1, 12'h000, 32'h80);
        settle();
        chk(32'(asw), 32'h0);
        chk(32'({poen, pout}), 32'h6);
        chk(32'(pread), 32'h2);
        // clock enable low freezes the read path
        ce <= 1'b0;
        pin <= 2'h1;
        settle();
        chk(32'(pread), 32'h2);
        ce <= 1'b1;
        settle();
        chk(32'(pread), 32'h1);
        for (int p = 0; p < 3; p++)
            for (int n = 0; n < 2; n++)
            begin
                apb(1'b1, 12'h000, 32'(p * 4 + n));
                settle();
                chk(32'(ssw), 32'({p == 0, p == 1, p == 2, n == 1, n == 0}));
            end
        chk(32'({on, cmp, adc}), 32'h0);
        $display("test done: sources");
        foreach (lv[i])
        begin
            apb(1'b1, 12'h004, 32'(lv[i]));
            apb(1'b0, 12'h004, 32'h0);
            chk(rdata, 32'(lv[i]));
            chk(32'(tap), 32'(lv[i]));
        end
        apb(1'b1, 12'h008, 32'hff);
        chk(32'(rerr), 32'h1);
        stb <= 4'h0;
        apb(1'b1, 12'h004, 32'h33);
        stb <= 4'hf;
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 32'h5a);
        chk(32'(rerr), 32'h0);
        $display("test done: level code");
        apb(1'b1, 12'h000, 32'hb0);
        settle();
        chk(32'({on, asw, tap}), 32'h75a);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(32'({on, asw, tap}), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 32'h0);
        settle();
        chk(32'({on, asw, tap}), 32'h0);
        $display("test done: reset");
        wrap_up();
    end
endmodule : testbench
